// *** rtl/msdma_pkg.sv ***
// Shared constants for the mass-storage DMA controller
package msdma_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] OFF_CS1  = 8'h00;
    localparam logic [7:0] OFF_WC   = 8'h04;
    localparam logic [7:0] OFF_BA   = 8'h08;
    localparam logic [7:0] OFF_BAE  = 8'h0c;
    localparam logic [7:0] OFF_CS2  = 8'h10;
    localparam logic [7:0] OFF_CS3  = 8'h14;
    localparam logic [7:0] OFF_DB   = 8'h18;
    localparam logic [7:0] OFF_ISTS = 8'h1c;
    localparam logic [7:0] OFF_IEN  = 8'h20;
    localparam logic [7:0] OFF_ICLR = 8'h24;
    // Control/status one fields
    localparam int CS1_SC   = 15;
    localparam int CS1_TRE  = 14;
    localparam int CS1_A16  = 8;
    localparam int CS1_RDY  = 7;
    localparam int CS1_IE   = 6;
    // Control/status two fields
    localparam int CS2_PGE  = 10;
    localparam int CS2_NEM  = 11;
    localparam int CS2_DPE  = 13;
    localparam int CS2_CLR  = 5;
    // Control/status three fields
    localparam int CS3_MDPE = 15;
    localparam int CS3_DPE  = 13;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_N    = 2;
    // Reset values
    localparam logic [15:0] WC_RST   = 16'h0000;
    localparam logic [21:0] ADDR_RST = 22'h000000;
    localparam logic [2:0]  SEL_RST  = 3'h0;
    // Drive word is 16 data bits plus one odd parity bit
    localparam int WORD_W = 16;
    localparam int ENTRY_W = 17;
    localparam int BUF_DEPTH = 8;
    localparam int DRIVES = 8;
endpackage : msdma_pkg

// *** rtl/word_buffer.sv ***
// Eight-entry word buffer, one or two words in and out per cycle
`timescale 1ns/100ps
module word_buffer #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       flush,
    input  wire logic [1:0]                 push_n,
    input  wire logic [WIDTH-1:0]           push_d0,
    input  wire logic [WIDTH-1:0]           push_d1,
    input  wire logic [1:0]                 pop_n,
    output logic      [WIDTH-1:0]           head0,
    output logic      [WIDTH-1:0]           head1,
    output logic      [$clog2(DEPTH):0]     level
);
    localparam int AW = $clog2(DEPTH);

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("word_buffer: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      lvl_q;
    wire  [AW-1:0]    wp1 = wp_q + AW'(1);
    wire  [AW-1:0]    rp1 = rp_q + AW'(1);

    assign head0 = mem_q[rp_q];
    assign head1 = mem_q[rp1];
    assign level = lvl_q;

    // Caller keeps pushes within room and pops within level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            lvl_q <= '0;
        end else if (flush) begin
            wp_q  <= '0;
            rp_q  <= '0;
            lvl_q <= '0;
        end else begin
            wp_q  <= wp_q + AW'(push_n);
            rp_q  <= rp_q + AW'(pop_n);
            lvl_q <= lvl_q + (AW+1)'(push_n) - (AW+1)'(pop_n);
        end
    end

    always_ff @(posedge pclk) begin
        if (push_n != 2'd0)
            mem_q[wp_q] <= push_d0;
        if (push_n == 2'd2)
            mem_q[wp1] <= push_d1;
    end

    chk_buf_bound: assert property (@(posedge pclk)
        disable iff (!presetn) lvl_q <= (AW+1)'(DEPTH))
        else $error("buffer level beyond depth");
endmodule : word_buffer

// *** rtl/msdma_ctrl.sv ***
// Mass-storage DMA controller: registers, transfer engine, parity
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
module msdma_ctrl #(
    parameter int DEPTH = msdma_pkg::BUF_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        irq_ack,
    output logic      [2:0]  drv_sel,
    output logic      [5:0]  drv_cmd,
    output logic             drv_cmd_par,
    output logic             drv_cmd_stb,
    input  wire logic [5:0]  drv_fn,
    input  wire logic        drv_err,
    output logic      [15:0] drv_tx_data,
    output logic             drv_tx_par,
    output logic             drv_tx_valid,
    input  wire logic        drv_tx_take,
    input  wire logic [15:0] drv_rx_data,
    input  wire logic        drv_rx_par,
    input  wire logic        drv_rx_valid,
    output logic             drv_rx_ready,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [21:0] mem_addr,
    output logic             mem_apar,
    output logic      [1:0]  mem_be,
    output logic      [31:0] mem_wdata,
    output logic      [3:0]  mem_wpar,
    output logic             mem_inval,
    input  wire logic        mem_gnt,
    input  wire logic [31:0] mem_rdata,
    input  wire logic [3:0]  mem_rpar,
    input  wire logic        mem_err
);
    import msdma_pkg::*;

    localparam int LW = $clog2(DEPTH) + 1;
    if (DEPTH < 2) begin : g_bad_depth
        $error("msdma_ctrl: DEPTH must be at least 2");
    end

    typedef enum logic [1:0] {st_idle, st_run} state_e;
    state_e state_q;

    logic        pready_q;
    logic [31:0] prdata_q;
    logic [15:0] wc_q;
    logic [21:0] addr_q;
    logic [2:0]  sel_q;
    logic        ie_q;
    logic        to_drv_q;
    logic        dec_q;
    logic        pge_q, nem_q, dpe_q, mdpe_q, dex_q;
    logic [15:0] db_q;
    logic [IRQ_N-1:0] ists_q, ien_q;
    logic        rdy_d1_q;
    logic        tre_d1_q;

    // Bus decode
    wire acc   = psel & penable & pready_q;
    wire wr    = acc & pwrite;
    wire s_cs1 = paddr == OFF_CS1;
    wire s_wc  = paddr == OFF_WC;
    wire s_ba  = paddr == OFF_BA;
    wire s_bae = paddr == OFF_BAE;
    wire s_cs2 = paddr == OFF_CS2;
    wire s_cs3 = paddr == OFF_CS3;
    wire s_db  = paddr == OFF_DB;
    wire s_ist = paddr == OFF_ISTS;
    wire s_ien = paddr == OFF_IEN;
    wire s_icl = paddr == OFF_ICLR;
    wire mapped = s_cs1 | s_wc | s_ba | s_bae | s_cs2 | s_cs3 |
                  s_db | s_ist | s_ien | s_icl;

    wire busy  = state_q == st_run;
    wire rdy   = ~busy;
    wire [5:0] fn_w = pwdata[5:0];
    wire xfer_code = fn_w[5] & (fn_w[4] | fn_w[3]) & fn_w[0];
    wire wr_cs1 = wr & s_cs1;
    wire launch = wr_cs1 & xfer_code & rdy;
    wire bad_go = wr_cs1 & xfer_code & busy;
    wire ctl_clr = wr & s_cs2 & pwdata[CS2_CLR];
    wire err_clr = wr_cs1 & pwdata[CS1_TRE];
    wire tre   = pge_q | nem_q | dpe_q | mdpe_q | dex_q;
    wire sc    = tre;

    // Buffer
    logic [1:0]          push_n, pop_n;
    logic [ENTRY_W-1:0]  pd0, pd1, h0, h1;
    logic [LW-1:0]       lvl;

    word_buffer #(
        .WIDTH (ENTRY_W),
        .DEPTH (DEPTH)
    ) u_buf (
        .pclk    (pclk),
        .presetn (presetn),
        .flush   (~busy),
        .push_n  (push_n),
        .push_d0 (pd0),
        .push_d1 (pd1),
        .pop_n   (pop_n),
        .head0   (h0),
        .head1   (h1),
        .level   (lvl)
    );

    // Words still to move; count is held negative
    wire [15:0] rem   = 16'h0000 - wc_q;
    wire [1:0]  n     = (rem == 16'h0001) ? 2'd1 : 2'd2;
    wire [LW-1:0] room = LW'(DEPTH) - lvl;
    // Only full pairs occupy the path, except a final odd word
    wire want = busy & (rem != 16'h0000) & (to_drv_q ?
                (room >= LW'(n)) : (lvl >= LW'(n)));
    wire cyc  = mem_req & mem_gnt;

    // Odd parity per byte on memory, per word on drive
    wire [3:0] rd_par_ok;
    wire [3:0] wr_par;
    for (genvar i = 0; i < 4; i++) begin : g_par
        assign rd_par_ok[i] = mem_rpar[i] == ~^mem_rdata[8*i +: 8];
        assign wr_par[i]    = ~^mem_wdata[8*i +: 8];
    end
    wire mdpe_ev = cyc & ~mem_we & (rd_par_ok != 4'hf);
    wire dpe_ev  = drv_rx_valid & drv_rx_ready &
                   (drv_rx_par != ~^drv_rx_data);

    // Memory side: data goes straight to memory, never cached
    assign mem_req   = want & ~tre;
    assign mem_we    = ~to_drv_q;
    assign mem_addr  = addr_q;
    assign mem_apar  = ~^{addr_q, mem_we};
    assign mem_be    = (n == 2'd2) ? 2'b11 : 2'b01;
    assign mem_wdata = {h1[WORD_W-1:0], h0[WORD_W-1:0]};
    assign mem_wpar  = wr_par;
    assign mem_inval = mem_req & mem_we;

    // Drive side: data streams while commands pass separately
    assign drv_tx_valid = busy & to_drv_q & (lvl != '0);
    assign drv_tx_data  = h0[WORD_W-1:0];
    assign drv_tx_par   = h0[WORD_W];
    assign drv_rx_ready = busy & ~to_drv_q & (room != '0);
    assign drv_sel      = sel_q;
    assign drv_cmd      = fn_w;
    assign drv_cmd_par  = ~^fn_w;
    // Every CS1 write starts a drive register cycle
    assign drv_cmd_stb  = wr_cs1;

    assign pd0 = to_drv_q ? {~^mem_rdata[15:0], mem_rdata[15:0]}
                          : {drv_rx_par, drv_rx_data};
    assign pd1 = {~^mem_rdata[31:16], mem_rdata[31:16]};
    assign push_n = to_drv_q ? (cyc ? n : 2'd0)
                  : {1'b0, drv_rx_valid & drv_rx_ready};
    assign pop_n  = to_drv_q ? {1'b0, drv_tx_valid & drv_tx_take}
                  : (cyc ? n : 2'd0);

    // Address steps by bytes moved; carry runs into extension
    wire [21:0] step = {19'h0, n, 1'b0};
    wire [21:0] addr_nx = dec_q ? addr_q - step : addr_q + step;

    // Register read mux
    wire [15:0] cs1_rd = {sc, tre, 1'b0, 2'b00, 1'b0,
                          addr_q[17:16], rdy, ie_q, drv_fn};
    wire [15:0] cs2_rd = {2'b00, dpe_q, 1'b0, nem_q, pge_q,
                          7'h00, sel_q};
    wire [15:0] cs3_rd = {mdpe_q, 1'b0, dpe_q, 13'h0000};
    wire [31:0] rd_mux =
        s_cs1 ? {16'h0000, cs1_rd} :
        s_wc  ? {16'h0000, wc_q} :
        s_ba  ? {16'h0000, addr_q[15:0]} :
        s_bae ? {26'h0, addr_q[21:16]} :
        s_cs2 ? {16'h0000, cs2_rd} :
        s_cs3 ? {16'h0000, cs3_rd} :
        s_db  ? {16'h0000, db_q} :
        s_ist ? {30'h0, ists_q} :
        s_ien ? {30'h0, ien_q} : 32'h00000000;

    // One wait state so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            if (psel & penable & ~pready_q & ~pwrite)
                prdata_q <= rd_mux;
        end
    end
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = acc & ~mapped;

    // Transfer sequencer
    wire done = to_drv_q ? (rem == 16'h0000) & (lvl == '0)
                         : (rem == 16'h0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state_q <= st_idle;
        else if (ctl_clr)
            state_q <= st_idle;
        else if (launch)
            state_q <= st_run;
        else if (busy & (done | tre))
            state_q <= st_idle;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_drv_q <= 1'b0;
            dec_q    <= 1'b0;
        end else if (launch) begin
            // Write and write-check read memory; reads fill it
            to_drv_q <= ~(fn_w[4] & (fn_w[3] | fn_w[2]) & ~fn_w[5]
                        ) & ~(fn_w[4] & fn_w[3]);
            dec_q    <= ~fn_w[2] & ~fn_w[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wc_q <= WC_RST;
        else if (ctl_clr)
            wc_q <= WC_RST;
        else if (cyc)
            wc_q <= wc_q + {14'h0000, n};
        else if (wr & s_wc)
            wc_q <= pwdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            addr_q <= ADDR_RST;
        else if (ctl_clr)
            addr_q <= ADDR_RST;
        else if (cyc)
            addr_q <= addr_nx;
        else if (wr & s_ba)
            addr_q[15:0] <= {pwdata[15:1], 1'b0};
        else if (wr & s_bae)
            addr_q[21:16] <= pwdata[5:0];
        else if (wr_cs1 & rdy)
            addr_q[17:16] <= pwdata[CS1_A16 +: 2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= SEL_RST;
            db_q  <= 16'h0000;
        end else begin
            if (wr & s_cs2)
                sel_q <= pwdata[2:0];
            if (wr & s_db)
                db_q <= pwdata[15:0];
        end
    end

    // Error flags: a new error wins over any clear
    wire eclr = ctl_clr | err_clr | launch;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pge_q  <= 1'b0;
            nem_q  <= 1'b0;
            dpe_q  <= 1'b0;
            mdpe_q <= 1'b0;
            dex_q  <= 1'b0;
        end else begin
            pge_q  <= bad_go | (pge_q & ~eclr);
            nem_q  <= (cyc & mem_err) | (nem_q & ~eclr);
            dpe_q  <= dpe_ev | (dpe_q & ~eclr);
            mdpe_q <= mdpe_ev | (mdpe_q & ~eclr);
            dex_q  <= (busy & drv_err) | (dex_q & ~eclr);
        end
    end

    // Enable bit; recognition by the host clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ie_q <= 1'b0;
        else if (ctl_clr | irq_ack)
            ie_q <= 1'b0;
        else if (wr_cs1)
            ie_q <= pwdata[CS1_IE];
    end

    // Interrupt events: ready rising, error appearing, or a CS1 write setting IE and RDY
    wire rdy_rise = rdy & ~rdy_d1_q;
    wire sw_irq   = wr_cs1 & pwdata[CS1_IE] & pwdata[CS1_RDY];
    wire [IRQ_N-1:0] ev;
    assign ev[IRQ_DONE] = (rdy_rise & ie_q) | sw_irq;
    assign ev[IRQ_ERR]  = tre & ~tre_d1_q & ie_q;
    wire [IRQ_N-1:0] iclr = (wr & s_icl) ? pwdata[IRQ_N-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_d1_q <= 1'b1;
            tre_d1_q <= 1'b0;
            ists_q   <= '0;
            ien_q    <= '0;
        end else begin
            rdy_d1_q <= rdy;
            tre_d1_q <= tre;
            ists_q   <= ev | (ists_q & ~iclr);
            if (wr & s_ien)
                ien_q <= pwdata[IRQ_N-1:0];
        end
    end
    assign irq = |(ists_q & ien_q);

    chk_launch_busy: assert property (@(posedge pclk)
        disable iff (!presetn) launch & ~ctl_clr |=> busy)
        else $error("launch did not make controller busy");
    chk_busy_no_go: assert property (@(posedge pclk)
        disable iff (!presetn) wr_cs1 & xfer_code & busy |=> pge_q)
        else $error("transfer command while busy not flagged");
    chk_wc_step: assert property (@(posedge pclk)
        disable iff (!presetn) cyc & ~ctl_clr |=>
        wc_q == $past(wc_q) + {14'h0000, $past(n)})
        else $error("word count did not step by words moved");
    chk_req_pair: assert property (@(posedge pclk)
        disable iff (!presetn) mem_req & mem_we |->
        lvl >= LW'(n) && (n == 2'd2 || rem == 16'h0001))
        else $error("memory write without full pair");
    chk_inval_write: assert property (@(posedge pclk)
        disable iff (!presetn) mem_req & mem_we |-> mem_inval)
        else $error("memory write without cache invalidate");
    chk_ack_clears_ie: assert property (@(posedge pclk)
        disable iff (!presetn) irq_ack |=> ~ie_q)
        else $error("interrupt recognition left enable set");
    chk_done_irq: assert property (@(posedge pclk)
        disable iff (!presetn) rdy_rise & ie_q & ien_q[IRQ_DONE]
        |=> irq)
        else $error("ready with enable gave no interrupt");
    chk_ready_wait: assert property (@(posedge pclk)
        disable iff (!presetn) $rose(psel & penable) |->
        ~pready ##1 pready)
        else $error("bus answer not one wait state");
    chk_mem_parity: assert property (@(posedge pclk)
        disable iff (!presetn) mdpe_ev |=> cs3_rd[CS3_MDPE])
        else $error("memory parity error not recorded");
endmodule : msdma_ctrl

// *** sim/drive_mem_model.sv ***
// Drive and main-memory responder model facing the DMA controller
`timescale 1ns/100ps
module drive_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        stall,
    input  wire logic        bad_par,
    input  wire logic [15:0] rx_seed,
    input  wire logic [5:0]  drv_cmd,
    input  wire logic        drv_cmd_stb,
    output logic      [5:0]  drv_fn,
    input  wire logic        drv_tx_valid,
    output logic             drv_tx_take,
    output logic      [15:0] drv_rx_data,
    output logic             drv_rx_par,
    output logic             drv_rx_valid,
    input  wire logic        drv_rx_ready,
    input  wire logic        mem_req,
    input  wire logic [21:0] mem_addr,
    output logic             mem_gnt,
    output logic      [31:0] mem_rdata,
    output logic      [3:0]  mem_rpar
);
    logic [15:0] cnt_q;
    logic [15:0] word_q;
    logic [31:0] pair;
    function automatic logic [15:0] word_at(input logic [21:0] a);
        return a[16:1] * 16'h0007 ^ 16'h5a3c;
    endfunction : word_at
    // Read data follow the address; inverted while no cycle is pending
    assign pair = {word_at(mem_addr + 22'h2), word_at(mem_addr)};
    assign mem_rdata = mem_req ? pair : ~pair;
    assign mem_rpar = {~^mem_rdata[31:24], ~^mem_rdata[23:16],
                       ~^mem_rdata[15:8], ~^mem_rdata[7:0] ^ bad_par};
    // Released data lines show the inverse so a stale word never matches
    assign drv_rx_data = drv_rx_valid ? word_q : ~word_q;
    assign drv_rx_par = ~^drv_rx_data;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_fn       <= 6'h00;
            drv_tx_take  <= 1'b0;
            drv_rx_valid <= 1'b0;
            word_q       <= 16'h0000;
            cnt_q        <= 16'h0000;
            mem_gnt      <= 1'b0;
        end else begin
            // Grants come late at random, never while stalled
            mem_gnt     <= !stall && $urandom_range(0, 3) != 0;
            drv_tx_take <= $urandom_range(0, 2) != 0;
            if (drv_cmd_stb) begin
                drv_fn       <= drv_cmd;
                cnt_q        <= 16'h0000;
                word_q       <= rx_seed;
                drv_rx_valid <= 1'b0;
            end else if (drv_rx_valid && drv_rx_ready) begin
                cnt_q        <= cnt_q + 16'h1;
                word_q       <= rx_seed + (cnt_q + 16'h1) * 16'h0101;
                drv_rx_valid <= 1'($urandom_range(0, 1));
            end else if (!drv_rx_valid) begin
                drv_rx_valid <= 1'($urandom_range(0, 1));
            end
        end
    end
endmodule : drive_mem_model

// *** sim/msdma_ctrl_tb.sv ***
// Self-checking bench for the mass-storage DMA controller
`timescale 1ns/100ps
module msdma_ctrl_tb;
    import msdma_pkg::*;
    typedef struct packed {
        logic [21:0] a;
        logic        we;
        logic [1:0]  be;
        logic [31:0] d;
    } mrec_s;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, irq_ack = 1'b0, stall = 1'b0;
    logic        bad_par = 1'b0, drv_err = 1'b0, mem_err = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_rdata, mem_wdata;
    logic [15:0] rx_seed = 16'h0, drv_tx_data, drv_rx_data;
    logic        pready, pslverr, irq, last_err, drv_cmd_par, drv_cmd_stb;
    logic        drv_tx_par, drv_tx_valid, drv_tx_take, drv_rx_par;
    logic        drv_rx_valid, drv_rx_ready, mem_req, mem_we, mem_apar;
    logic        mem_inval, mem_gnt;
    logic [2:0]  drv_sel;
    logic [5:0]  drv_cmd, drv_fn;
    logic [21:0] mem_addr;
    logic [1:0]  mem_be;
    logic [3:0]  mem_wpar, mem_rpar;
    logic [15:0] tx_q[$];
    mrec_s       mq[$];
    int          err_total = 0;
    int          checks = 0;

    msdma_ctrl i_msdma_ctrl (.*);
    drive_mem_model i_drive_mem_model (.*);

    always #2 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            complete_run();
        end
        r = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic reg_is(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask : reg_is

    task automatic irq_is(input logic e);
        @(negedge pclk);
        chk(irq, e);
        @(posedge pclk);
    endtask : irq_is

    function automatic logic [3:0] par4(input logic [31:0] d);
        return {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]};
    endfunction : par4

    // Polling keeps every wait bounded even if ready never returns
    task automatic wait_rdy();
        logic [31:0] r;
        for (int i = 0; i < 500; i++) begin
            apb(1'b0, OFF_CS1, 32'h0, r);
            if (r[CS1_RDY] === 1'b1) return;
        end
        err_total++;
        complete_run();
    endtask : wait_rdy

    function automatic logic [15:0] word_of(input logic to_mem,
                                            input logic [15:0] s,
                                            input int i);
        logic [21:0] ad;
        ad = {6'h0, s} + 22'(2 * i);
        if (to_mem) return s + 16'(i) * 16'h0101;
        return ad[16:1] * 16'h0007 ^ 16'h5a3c;
    endfunction : word_of

    task automatic go(input logic [5:0] code, input int n,
                      input logic [15:0] a);
        wr(OFF_WC, {16'h0, 16'(-n)});
        wr(OFF_BA, {16'h0, a});
        wr(OFF_BAE, 32'h0);
        wr(OFF_CS1, {25'h0, 1'b1, code});
    endtask : go

    task automatic xfer(input logic [5:0] code, input int n,
                        input logic [15:0] a);
        logic        to_mem;
        logic [15:0] s;
        to_mem = code[3];
        tx_q.delete();
        mq.delete();
        go(code, n, a);
        s = to_mem ? rx_seed : a;
        wait_rdy();
        reg_is(OFF_WC, 32'hffff, 32'h0);
        reg_is(OFF_BA, 32'hffff, {16'h0, a + 16'(2 * n)});
        chk(mq.size(), (n + 1) / 2);
        chk(tx_q.size(), to_mem ? 0 : n);
        foreach (tx_q[i]) chk(tx_q[i], word_of(1'b0, s, i));
        foreach (mq[k]) begin
            chk(mq[k].a, {6'h0, a} + 22'(4 * k));
            chk(mq[k].we, to_mem);
            chk(mq[k].be, (2 * k + 1 < n) ? 2'h3 : 2'h1);
            if (to_mem) begin
                chk(mq[k].d[15:0], word_of(1'b1, s, 2 * k));
                if (2 * k + 1 < n) begin
                    chk(mq[k].d[31:16], word_of(1'b1, s, 2 * k + 1));
                end
            end
        end
        irq_is(1'b1);
        @(posedge pclk);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        reg_is(OFF_CS1, 32'h40, 32'h0);
        reg_is(OFF_ISTS, 32'h1, 32'h1);
        wr(OFF_ICLR, 32'h3);
        irq_is(1'b0);
    endtask : xfer

    always @(posedge pclk) begin
        if (drv_tx_valid === 1'b1 && drv_tx_take === 1'b1) begin
            tx_q.push_back(drv_tx_data);
            chk(drv_tx_par, ~^drv_tx_data);
        end
        if (mem_req === 1'b1 && mem_gnt === 1'b1) begin
            mq.push_back(mrec_s'{mem_addr, mem_we, mem_be, mem_wdata});
            chk(mem_apar, ~^{mem_addr, mem_we});
            chk(mem_inval, mem_we);
            if (mem_we === 1'b1 && mem_be === 2'h3)
                chk(mem_wpar, par4(mem_wdata));
        end
        if (drv_cmd_stb === 1'b1) chk(drv_cmd_par, ~^drv_cmd);
    end

    initial begin
        logic [31:0] r;
        logic [15:0] a;
        void'($urandom(29));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        reg_is(OFF_CS1, 32'hffff, 32'h0080);
        reg_is(OFF_WC, 32'hffff, {16'h0, WC_RST});
        reg_is(OFF_ISTS, 32'h3, 32'h0);
        apb(1'b0, 8'h28, 32'h0, r);
        chk(r, 32'h0);
        chk(last_err, 1'b1);
        a = 16'($urandom) & 16'hfffc;
        wr(OFF_BA, {16'h0, a});
        reg_is(OFF_BA, 32'hffff, {16'h0, a});
        wr(OFF_DB, {16'h0, ~a});
        reg_is(OFF_DB, 32'hffff, {16'h0, ~a});
        wr(OFF_CS2, 32'h5);
        @(negedge pclk);
        chk(drv_sel, 3'h5);
        wr(OFF_CS1, 32'h1);
        reg_is(OFF_CS1, 32'hbf, 32'h81);
        wr(OFF_IEN, 32'h3);
        // Lengths beyond the buffer depth and odd counts are both drawn
        for (int t = 0; t < 6; t++) begin
            rx_seed <= 16'($urandom);
            a = 16'($urandom_range(0, 16'h3ff0)) & 16'hfffc;
            xfer(t[0] ? 6'h3b : 6'h33, $urandom_range(1, 9), a);
        end
        wr(OFF_IEN, 32'h0);
        wr(OFF_CS1, 32'hc0);
        reg_is(OFF_ISTS, 32'h1, 32'h1);
        irq_is(1'b0);
        wr(OFF_IEN, 32'h1);
        irq_is(1'b1);
        wr(OFF_ICLR, 32'h1);
        irq_is(1'b0);
        stall <= 1'b1;
        go(6'h33, 4, 16'h0100);
        reg_is(OFF_CS1, 32'h80, 32'h0);
        wr(OFF_CS1, 32'h73);
        reg_is(OFF_CS2, 32'h400, 32'h400);
        wait_rdy();
        stall <= 1'b0;
        reg_is(OFF_CS1, 32'h4000, 32'h4000);
        reg_is(OFF_ISTS, 32'h2, 32'h2);
        wr(OFF_CS2, 32'h20);
        reg_is(OFF_CS1, 32'h4000, 32'h0);
        wr(OFF_ICLR, 32'h3);
        bad_par <= 1'b1;
        go(6'h33, 2, 16'h0200);
        wait_rdy();
        bad_par <= 1'b0;
        reg_is(OFF_CS3, 32'h8000, 32'h8000);
        drv_err <= 1'b1;
        go(6'h33, 2, 16'h0300);
        wait_rdy();
        drv_err <= 1'b0;
        reg_is(OFF_CS1, 32'h4000, 32'h4000);
        // Decrementing read into memory walks the address down a pair
        go(6'h39, 2, 16'h0400);
        wait_rdy();
        reg_is(OFF_BA, 32'hffff, 32'h03fc);
        complete_run();
    end
endmodule : msdma_ctrl_tb
